// ---- rtl/pssc_cfg.svh ----
/*
 * Constants of the PHY status summary and false carrier counter block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes it is included by its bare name from rtl/ and verification/ files.
 */
// Overview of operation
// - Jabber bit 5 only carries meaning at 10 Mb/s; reads zero at 100.
// - Bit 5 mirrors the basic status jabber flag; summary reads never clear it.
// - Bit 4 is one once auto-negotiation completed, zero otherwise; resets to zero.
// - Bit 2 is one for full duplex, zero for half duplex.
// - Duplex and speed come from negotiation result, or forced settings without it.
// - Bit 1 is one at 10 Mb/s, zero at 100 Mb/s.
// - Bit 0 mirrors the basic status link flag; summary reads never clear it.
// - Bit 0 is one with valid link at 10 or 100, zero without link.
// - Counter bits 7:0 increment once per false carrier event.
// - The false carrier count sticks at its maximum instead of wrapping.
// - Counter bits 15:8 ignore writes and always read zero.
// - The count is read-only, resets to zero, and clears when read.
`ifndef PSSC_CFG_SVH
`define PSSC_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PSSC_ADDR_W        5
`define PSSC_DATA_W        16
`define PSSC_OFF_SUMMARY   5'h10
`define PSSC_OFF_FC_COUNT  5'h14
`define PSSC_OFF_INT_STAT  5'h1A
`define PSSC_OFF_INT_MASK  5'h1B

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define PSSC_SUM_W         6
`define PSSC_FC_W          8
`define PSSC_INT_W         4

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PSSC_SUM_RST       6'h00
`define PSSC_FC_RST        8'h00
`define PSSC_FC_MAX        8'hFF
`define PSSC_INT_RST       4'h0
`define PSSC_DATA_ZERO     16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSSC_RD_LATENCY    1

`endif

// ---- rtl/pssc_pkg.sv ----
/*
 * Types shared by the PHY status summary block.
 * Assumes pssc_cfg.svh is on the include path.
 */
`include "pssc_cfg.svh"

package pssc_pkg;

	// ----------------------------------------
	// Register port request
	// ----------------------------------------
	typedef struct packed {
		logic [`PSSC_ADDR_W-1:0] addr;
		logic [`PSSC_DATA_W-1:0] wdata;
		logic                    wr;
		logic                    rd;
	} pssc_bus_t;

	// ----------------------------------------
	// Conditions from PCS, negotiation and link monitor
	// ----------------------------------------
	typedef struct packed {
		logic jabber;
		logic an_enable;
		logic an_complete;
		logic an_full_duplex;
		logic an_speed10;
		logic forced_full_duplex;
		logic forced_speed10;
		logic loopback;
		logic link_ok;
	} pssc_src_t;

	// ----------------------------------------
	// Summary bits 5:0, msb first
	// ----------------------------------------
	typedef struct packed {
		logic jabber;
		logic an_complete;
		logic loopback;
		logic full_duplex;
		logic speed10;
		logic link;
	} pssc_sum_t;

	// ----------------------------------------
	// Interrupt sources, bit 3 down to bit 0
	// ----------------------------------------
	typedef struct packed {
		logic an_done;
		logic jabber;
		logic false_carrier;
		logic link_chg;
	} pssc_int_t;

endpackage

// ---- rtl/pssc_regs.sv ----
/*
 * PHY status summary register, clear-on-read false carrier counter and
 * a small interrupt status and mask pair, on a plain strobe register port.
 * Assumes all source conditions and the event pulse come from logic on
 * clk_sys, and that read and write strobes are single cycles, never both.
 */
`timescale 1ns/1ps
`include "pssc_cfg.svh"

module pssc_regs
	import pssc_pkg::*;
#(
	parameter int FC_W = `PSSC_FC_W
) (
	input  wire logic                    clk_sys,
	input  wire logic                    nrst,
	input  wire pssc_bus_t               bus,
	output logic      [`PSSC_DATA_W-1:0] rdata,
	input  wire pssc_src_t               src,
	input  wire logic                    false_carrier_evt,
	output logic                         irq
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic sel_sum;
	logic sel_fc;
	logic sel_ist;
	logic sel_imk;
	logic rd_fc;
	logic wr_ist;
	logic wr_imk;

	assign sel_sum = (bus.addr == `PSSC_OFF_SUMMARY);
	assign sel_fc  = (bus.addr == `PSSC_OFF_FC_COUNT);
	assign sel_ist = (bus.addr == `PSSC_OFF_INT_STAT);
	assign sel_imk = (bus.addr == `PSSC_OFF_INT_MASK);
	assign rd_fc   = bus.rd && sel_fc;
	assign wr_ist  = bus.wr && sel_ist;
	assign wr_imk  = bus.wr && sel_imk;

	// ----------------------------------------
	// Status summary
	// ----------------------------------------
	pssc_sum_t sum_r;
	pssc_sum_t sum_nxt;
	logic      speed10_sel;
	logic      duplex_sel;

	always_comb begin
		// Negotiated result wins only when negotiation is in use
		speed10_sel = src.an_enable ? src.an_speed10 : src.forced_speed10;
		duplex_sel  = src.an_enable ? src.an_full_duplex : src.forced_full_duplex;
		sum_nxt             = sum_r;
		// Gated so a stale jabber at 100 Mb/s cannot mislead software
		sum_nxt.jabber      = src.jabber && speed10_sel;
		sum_nxt.an_complete = src.an_complete;
		sum_nxt.loopback    = src.loopback;
		sum_nxt.full_duplex = duplex_sel;
		sum_nxt.speed10     = speed10_sel;
		sum_nxt.link        = src.link_ok;
		// No bus term here: summary reads and writes leave it alone
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sum_r <= `PSSC_SUM_RST;
		end else begin
			sum_r <= sum_nxt;
		end
	end

	// ----------------------------------------
	// False carrier counter
	// ----------------------------------------
	logic [FC_W-1:0] fc_count;

	pssc_sat_counter #(
		.WIDTH (FC_W)
	) u_fc_cnt (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.inc     (false_carrier_evt),
		.clr     (rd_fc),
		.count   (fc_count)
	);

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	pssc_int_t int_st_r;
	pssc_int_t int_st_nxt;
	pssc_int_t int_mk_r;
	pssc_int_t int_mk_nxt;
	pssc_int_t int_ev;
	logic      link_prev_r;
	logic      link_prev_nxt;
	logic      jab_prev_r;
	logic      jab_prev_nxt;
	logic      an_prev_r;
	logic      an_prev_nxt;

	always_comb begin
		link_prev_nxt        = sum_r.link;
		jab_prev_nxt         = sum_r.jabber;
		an_prev_nxt          = sum_r.an_complete;
		int_ev.link_chg      = sum_r.link ^ link_prev_r;
		int_ev.false_carrier = false_carrier_evt;
		int_ev.jabber        = sum_r.jabber && !jab_prev_r;
		int_ev.an_done       = sum_r.an_complete && !an_prev_r;
		int_st_nxt           = int_st_r;
		if (wr_ist) begin
			int_st_nxt = int_st_r & ~bus.wdata[`PSSC_INT_W-1:0];
		end
		// Set after clear, so a same-cycle event is kept
		int_st_nxt = int_st_nxt | int_ev;
		int_mk_nxt = int_mk_r;
		if (wr_imk) begin
			int_mk_nxt = bus.wdata[`PSSC_INT_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			int_st_r    <= `PSSC_INT_RST;
			int_mk_r    <= `PSSC_INT_RST;
			link_prev_r <= 1'b0;
			jab_prev_r  <= 1'b0;
			an_prev_r   <= 1'b0;
		end else begin
			int_st_r    <= int_st_nxt;
			int_mk_r    <= int_mk_nxt;
			link_prev_r <= link_prev_nxt;
			jab_prev_r  <= jab_prev_nxt;
			an_prev_r   <= an_prev_nxt;
		end
	end

	assign irq = |(int_st_r & int_mk_r);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [`PSSC_DATA_W-1:0] rdata_r;
	logic [`PSSC_DATA_W-1:0] rdata_nxt;

	always_comb begin
		rdata_nxt = `PSSC_DATA_ZERO;
		if (bus.rd) begin
			case (1'b1)
				sel_sum: begin
					rdata_nxt[`PSSC_SUM_W-1:0] = sum_r;
				end
				sel_fc: begin
					// Upper byte has no storage behind it
					rdata_nxt[FC_W-1:0] = fc_count;
				end
				sel_ist: begin
					rdata_nxt[`PSSC_INT_W-1:0] = int_st_r;
				end
				sel_imk: begin
					rdata_nxt[`PSSC_INT_W-1:0] = int_mk_r;
				end
				default: begin
					rdata_nxt = `PSSC_DATA_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= `PSSC_DATA_ZERO;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	property p_jabber_speed;
		sum_r.jabber |-> sum_r.speed10;
	endproperty
	a_jabber_speed: assert property (p_jabber_speed) else $error("Jabber shown at 100");

	property p_jabber_mirror;
		bus.rd && sel_sum ##1 (src.jabber && speed10_sel) [*2] |=> sum_r.jabber;
	endproperty
	a_jabber_mirror: assert property (p_jabber_mirror) else $error("Jabber copy lost");

	property p_an_done;
		src.an_complete ##1 src.an_complete |-> sum_r.an_complete;
	endproperty
	a_an_done: assert property (p_an_done) else $error("Negotiation done not shown");

	property p_loopback;
		1'b1 |=> sum_r.loopback == $past(src.loopback);
	endproperty
	a_loopback: assert property (p_loopback) else $error("Loopback bit wrong");

	property p_duplex;
		1'b1 |=> sum_r.full_duplex ==
			$past(src.an_enable ? src.an_full_duplex : src.forced_full_duplex);
	endproperty
	a_duplex: assert property (p_duplex) else $error("Duplex source wrong");

	property p_forced_speed;
		!src.an_enable && src.forced_speed10 |=> sum_r.speed10;
	endproperty
	a_forced_speed: assert property (p_forced_speed) else $error("Forced speed ignored");

	property p_speed;
		src.an_enable && !src.an_speed10 |=> !sum_r.speed10;
	endproperty
	a_speed: assert property (p_speed) else $error("Speed bit wrong at 100");

	property p_link_hold;
		bus.rd && sel_sum && src.link_ok ##1 src.link_ok |=> sum_r.link;
	endproperty
	a_link_hold: assert property (p_link_hold) else $error("Link copy cleared by read");

	property p_link;
		1'b1 |=> sum_r.link == $past(src.link_ok);
	endproperty
	a_link: assert property (p_link) else $error("Link bit wrong");

	property p_fc_inc;
		false_carrier_evt && !rd_fc && (fc_count != `PSSC_FC_MAX)
			|=> fc_count == $past(fc_count) + 8'h01;
	endproperty
	a_fc_inc: assert property (p_fc_inc) else $error("Count did not step");

	property p_fc_sat;
		(fc_count == `PSSC_FC_MAX) && !rd_fc |=> (fc_count == `PSSC_FC_MAX);
	endproperty
	a_fc_sat: assert property (p_fc_sat) else $error("Count wrapped");

	property p_fc_upper;
		rd_fc |=> rdata[`PSSC_DATA_W-1:FC_W] == 8'h00;
	endproperty
	a_fc_upper: assert property (p_fc_upper) else $error("Upper byte not zero");

	property p_fc_cor;
		rd_fc |=> (rdata[FC_W-1:0] == $past(fc_count))
			&& (fc_count == {7'h00, $past(false_carrier_evt)});
	endproperty
	a_fc_cor: assert property (p_fc_cor) else $error("Count not cleared on read");

	property p_sum_ro;
		bus.wr && sel_sum && $stable(src) |=> $stable(sum_r);
	endproperty
	a_sum_ro: assert property (p_sum_ro) else $error("Summary took a write");

	property p_irq;
		##1 irq == |($past(int_st_nxt) & $past(int_mk_nxt));
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt output wrong");

	property p_set_wins;
		wr_ist && bus.wdata[1] && false_carrier_evt |=> int_st_r.false_carrier;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Event lost to clear");

	property p_fc_int;
		false_carrier_evt |=> int_st_r.false_carrier;
	endproperty
	a_fc_int: assert property (p_fc_int) else $error("False carrier flag not set");

	property p_link_int;
		$changed(sum_r.link) |=> int_st_r.link_chg;
	endproperty
	a_link_int: assert property (p_link_int) else $error("Link change flag not set");

	property p_jab_int;
		$rose(sum_r.jabber) |=> int_st_r.jabber;
	endproperty
	a_jab_int: assert property (p_jab_int) else $error("Jabber flag not set");

	property p_an_int;
		$rose(sum_r.an_complete) |=> int_st_r.an_done;
	endproperty
	a_an_int: assert property (p_an_int) else $error("Negotiation flag not set");

	property p_mask_wr;
		wr_imk |=> int_mk_r == $past(bus.wdata[`PSSC_INT_W-1:0]);
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("Mask write lost");

	// Idle read data must be zero so a late sample cannot pass
	property p_rdata_idle;
		!bus.rd |=> rdata == `PSSC_DATA_ZERO;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside read slot");

	c_fc_read: cover property (rd_fc && (fc_count != 8'h00));
	c_fc_sat: cover property ((fc_count == `PSSC_FC_MAX) && false_carrier_evt);
	c_link_up: cover property (!sum_r.link ##1 sum_r.link);
	c_irq: cover property (!irq ##1 irq);

endmodule

// ---- rtl/pssc_sat_counter.sv ----
/*
 * Saturating event counter with synchronous clear.
 * Assumes inc and clr come from logic on clk_sys.
 */
`timescale 1ns/1ps

module pssc_sat_counter #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             inc,
	input  wire logic             clr,
	output logic      [WIDTH-1:0] count
);

	localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
	localparam logic [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;

	// ----------------------------------------
	// Next count
	// ----------------------------------------
	always_comb begin
		count_nxt = count_r;
		if (clr) begin
			// Event in the clearing cycle still counts
			count_nxt = inc ? CNT_ONE : '0;
		end else if (inc && (count_r != CNT_MAX)) begin
			count_nxt = count_r + CNT_ONE;
		end
		// Saturated count simply holds
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count = count_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_cnt_stick;
		@(posedge clk_sys) disable iff (!nrst)
		(count_r == CNT_MAX) && !clr |=> (count_r == CNT_MAX);
	endproperty
	a_cnt_stick: assert property (p_cnt_stick) else $error("Counter left its maximum");

endmodule

// ---- verification/pssc_src_model.sv ----
/*
 * Stand-in for the PCS, negotiation and link monitor logic that feeds the block.
 * Assumes the bench drives cfg, n and go from clk_sys by non-blocking assignment.
 */
`timescale 1ns/1ps

module pssc_src_model
	import pssc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire pssc_src_t  cfg,
	input  wire logic [8:0] n,
	input  wire logic       go,
	output pssc_src_t       src,
	output logic            evt
);
	// ----------------------------------------
	// Conditions and event burst
	// ----------------------------------------
	logic [8:0] left_r;

	// Conditions change only on the clock, as real link logic would
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			src    <= '0;
			left_r <= 9'h000;
			evt    <= 1'b0;
		end else begin
			src <= cfg;
			if (go && left_r == 9'h000) begin
				left_r <= n;
			end else if (left_r != 9'h000) begin
				left_r <= left_r - 9'h001;
			end
			// Back-to-back pulses, the worst case for the counter
			evt <= (left_r != 9'h000);
		end
	end
endmodule

// ---- verification/test_phy_status_false_carrier_regs.sv ----
/*
 * Self-checking bench for pssc_regs: summary bits, counter, interrupts.
 * Assumes pssc_cfg.svh on the include path and pssc_src_model as the source.
 */
`timescale 1ns/1ps
`include "pssc_cfg.svh"

module test_phy_status_false_carrier_regs;
	import pssc_pkg::*;

	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic        clk_sys;
	logic        nrst;
	pssc_bus_t   bus;
	logic [15:0] rdata;
	pssc_src_t   cfg;
	pssc_src_t   src;
	logic [8:0]  n;
	logic        go;
	logic        evt;
	logic        irq;
	int          mismatches;
	int          n_checks;

	pssc_regs uut (
		.clk_sys(clk_sys), .nrst(nrst), .bus(bus), .rdata(rdata),
		.src(src), .false_carrier_evt(evt), .irq(irq)
	);

	pssc_src_model model (
		.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .n(n), .go(go),
		.src(src), .evt(evt)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask

	// Read data exist only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		@(negedge clk_sys);
		d = rdata;
	endtask

	task automatic burst(input logic [8:0] k);
		@(posedge clk_sys);
		n  <= k;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (k + 4) @(posedge clk_sys);
	endtask

	function automatic logic [15:0] exp_sum(input pssc_src_t s);
		logic spd;
		logic dup;
		spd = s.an_enable ? s.an_speed10 : s.forced_speed10;
		dup = s.an_enable ? s.an_full_duplex : s.forced_full_duplex;
		return {10'h000, s.jabber & spd, s.an_complete, s.loopback, dup, spd, s.link_ok};
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [15:0] d;
		rd(`PSSC_OFF_SUMMARY, d);
		chk(d, 16'h0000);
		rd(`PSSC_OFF_FC_COUNT, d);
		chk(d, 16'h0000);
		@(negedge clk_sys);
		chk(rdata, 16'h0000);
		rd(5'h05, d);
		chk(d, 16'h0000);
		rd(`PSSC_OFF_INT_MASK, d);
		chk(d, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_summary;
		logic [15:0] d;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			cfg <= pssc_src_t'(9'(i * 37 + 5));
			repeat (4) @(posedge clk_sys);
			wr(`PSSC_OFF_SUMMARY, 16'hFFFF);
			rd(`PSSC_OFF_SUMMARY, d);
			chk(d, exp_sum(cfg));
			rd(`PSSC_OFF_SUMMARY, d);
			chk(d, exp_sum(cfg));
		end
		$display("test summary done");
	endtask

	task automatic t_counter;
		logic [15:0] d;
		burst(9'h003);
		wr(`PSSC_OFF_FC_COUNT, 16'hFFFF);
		rd(`PSSC_OFF_FC_COUNT, d);
		chk(d, 16'h0003);
		rd(`PSSC_OFF_FC_COUNT, d);
		chk(d, 16'h0000);
		burst(9'h104);
		rd(`PSSC_OFF_FC_COUNT, d);
		chk(d, 16'h00FF);
		rd(`PSSC_OFF_FC_COUNT, d);
		chk(d, 16'h0000);
		$display("test counter done");
	endtask

	task automatic t_irq;
		logic [15:0] d;
		wr(`PSSC_OFF_INT_MASK, 16'h0000);
		wr(`PSSC_OFF_INT_STAT, 16'h000F);
		rd(`PSSC_OFF_INT_STAT, d);
		chk(d, 16'h0000);
		burst(9'h001);
		rd(`PSSC_OFF_INT_STAT, d);
		chk(d, 16'h0002);
		chk({15'h0000, irq}, 16'h0000);
		wr(`PSSC_OFF_INT_MASK, 16'h0002);
		@(negedge clk_sys);
		chk({15'h0000, irq}, 16'h0001);
		wr(`PSSC_OFF_INT_STAT, 16'h0002);
		@(negedge clk_sys);
		chk({15'h0000, irq}, 16'h0000);
		rd(`PSSC_OFF_FC_COUNT, d);
		chk(d, 16'h0001);
		wr(`PSSC_OFF_INT_STAT, 16'h000F);
		@(posedge clk_sys);
		cfg <= pssc_src_t'(9'h145);
		repeat (4) @(posedge clk_sys);
		rd(`PSSC_OFF_INT_STAT, d);
		chk(d, 16'h000D);
		$display("test irq done");
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Run needs about 520 cycles; allow ample margin
	initial begin
		#200000;
		mismatches++;
		conclude();
	end

	initial begin
		mismatches = 0;
		n_checks   = 0;
		nrst       = 1'b0;
		bus        = '0;
		cfg        = '0;
		n          = 9'h000;
		go         = 1'b0;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset();
		t_summary();
		t_counter();
		t_irq();
		conclude();
	end
endmodule
